// file: inc/bool_eval_defs.svh
// constants for the boolean output logic evaluator
`ifndef BOOL_EVAL_DEFS_SVH
`define BOOL_EVAL_DEFS_SVH
`define OUT_COUNT 4
`define IN_COUNT 8
// register offsets
`define ADDR_CTRL 8'h00
`define ADDR_SOFT 8'h04
`define ADDR_DIRECT 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_MASK 8'h10
`define ADDR_ERR 8'h14
`define ADDR_INPUTS 8'h18
`define ADDR_OUTPUTS 8'h1C
`define ADDR_EXPR0 8'h20
// status field positions
`define ST_IN_LSB 0
`define ST_OUT_LSB 8
`define ST_ERR_LSB 12
// reset values
`define RST_WORD 32'h0000_0000
`endif

// file: inc/bool_eval_pkg.sv
// types for the boolean output logic evaluator
package bool_eval_pkg;
  // operand source kind
  typedef enum logic [2:0] {SRC_NONE, SRC_IN, SRC_IN_N, SRC_SOFT, SRC_SOFT_N} src_e;
  // operator kind
  typedef enum logic [1:0] {OP_NONE, OP_OR, OP_AND, OP_XOR} op_e;
  // one operand: kind plus channel index
  typedef struct packed {
    src_e kind;
    logic [2:0] idx;
  } operand_s;
  // one expression (A x B) y C
  typedef struct packed {
    op_e opY;
    op_e opX;
    operand_s c;
    operand_s b;
    operand_s a;
  } expr_s;
endpackage

// file: rtl/bool_eval.sv
// per-output boolean expression evaluator with register port and interrupts
// Notes on behaviour
// RULE1: each output: direct drive or expression
// RULE2: operands from inputs and soft inputs
// RULE3: interrupt on input or output change
// RULE4: expression true drives output on
// RULE5: independent expression per output
// RULE6: four expressions, three operands, two operators
// RULE7: combine a,b first, then with c
// RULE8: reset leaves all fields none
// RULE9: null expression holds output off
// RULE10: only four shapes accepted
// RULE11: single operand shape, output follows it
// RULE12: two operand shape checked
// RULE13: full shape needs all fields
// RULE14: host keeps and supplies configuration
// RULE15: operand selects none, input, soft, inverted
// RULE16: soft inputs written by host
// RULE17: operators none, or, and, xor
// RULE18: bad shape rejected, error flagged, old kept
// RULE19: evaluate every cycle on registered inputs
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "bool_eval_defs.svh"
`default_nettype none
module bool_eval
  import bool_eval_pkg::*;
#(
  parameter int NOUT = `OUT_COUNT,
  parameter int NIN = `IN_COUNT
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [NIN-1:0] inPins,
  output logic [NOUT-1:0] outPins,
  output logic irq
);
  // operand value from its selection
  // RULE2: operands from pins and soft bits
  function automatic logic opnd(input operand_s o, input logic [7:0] hw, input logic [7:0] sw);
    logic v;
    v = 1'b0;
    // RULE15: five operand kinds decoded
    // undefined kinds read as false, but the shape check refuses them anyway
    case (o.kind)
      SRC_IN: v = hw[o.idx];
      SRC_IN_N: v = ~hw[o.idx];
      SRC_SOFT: v = sw[o.idx];
      SRC_SOFT_N: v = ~sw[o.idx];
      default: v = 1'b0;
    endcase
    return v;
  endfunction
  // apply one operator
  function automatic logic apply(input op_e op, input logic l, input logic r);
    logic v;
    v = 1'b0;
    // RULE17: or, and, xor; none passes left
    // passing the left side lets a short shape ride through unused operators
    case (op)
      OP_OR: v = l | r;
      OP_AND: v = l & r;
      OP_XOR: v = l ^ r;
      default: v = l;
    endcase
    return v;
  endfunction
  // operand field holds a legal non-none code
  function automatic logic used(input operand_s o);
    return o.kind inside {SRC_IN, SRC_IN_N, SRC_SOFT, SRC_SOFT_N};
  endfunction
  // accepted shapes only
  function automatic logic shapeOk(input expr_s e);
    logic nA, nB, nC, nX, nY, okK;
    nA = used(e.a);
    nB = used(e.b);
    nC = used(e.c);
    nX = e.opX != OP_NONE;
    nY = e.opY != OP_NONE;
    okK = (e.a.kind inside {SRC_NONE, SRC_IN, SRC_IN_N, SRC_SOFT, SRC_SOFT_N})
      && (e.b.kind inside {SRC_NONE, SRC_IN, SRC_IN_N, SRC_SOFT, SRC_SOFT_N})
      && (e.c.kind inside {SRC_NONE, SRC_IN, SRC_IN_N, SRC_SOFT, SRC_SOFT_N});
    // RULE10: defined kinds, one of four shapes
    return okK && (
      // RULE9: null shape is accepted
      (!nA && !nB && !nC && !nX && !nY)
      // RULE11: single operand shape
      || (nA && !nB && !nC && !nX && !nY)
      // RULE12: two operands, first operator
      || (nA && nB && nX && !nC && !nY)
      // RULE13: full shape needs every field
      || (nA && nB && nC && nX && nY));
  endfunction

  // control: bit n selects expression mode for output n
  logic [NOUT-1:0] ctrl_reg;
  // soft inputs from host output image
  logic [NIN-1:0] soft_reg;
  // direct output values from host
  logic [NOUT-1:0] direct_reg;
  // applied expressions, one per output
  // RULE5: independent expression per output
  expr_s expr_reg [NOUT];
  // registered input sample and output state
  logic [NIN-1:0] inSmp_reg;
  logic [NOUT-1:0] out_reg;
  // sticky status and its mask
  logic [31:0] status_reg;
  logic [31:0] mask_reg;
  logic [31:0] rdata_reg;

  // write decode
  wire logic wrCtrl = wr && addr == `ADDR_CTRL;
  wire logic wrSoft = wr && addr == `ADDR_SOFT;
  wire logic wrDirect = wr && addr == `ADDR_DIRECT;
  wire logic wrStatus = wr && addr == `ADDR_STATUS;
  wire logic wrMask = wr && addr == `ADDR_MASK;
  // expression slot hit by this write
  wire logic wrExprRange = wr && addr >= `ADDR_EXPR0 && addr < 8'(`ADDR_EXPR0 + 4 * NOUT);
  wire logic [7:0] exprOff = addr - `ADDR_EXPR0;
  // RULE6: slot index from output number
  // two index bits limit the block to four expression slots
  wire logic [1:0] exprIdx = exprOff[3:2];
  wire expr_s newExpr = expr_s'(wdata[$bits(expr_s)-1:0]);
  wire logic newOk = shapeOk(newExpr);

  // expression result and next output per output
  logic [NOUT-1:0] exprVal;
  logic [NOUT-1:0] out_next;
  always_comb begin
    for (int n = 0; n < NOUT; n++) begin
      // RULE7: a x b first, then y c
      exprVal[n] = apply(expr_reg[n].opY,
        apply(expr_reg[n].opX,
          opnd(expr_reg[n].a, inSmp_reg, soft_reg),
          opnd(expr_reg[n].b, inSmp_reg, soft_reg)),
        opnd(expr_reg[n].c, inSmp_reg, soft_reg));
      // RULE1: mode select per output
      // RULE4: expression value drives output
      out_next[n] = ctrl_reg[n] ? exprVal[n] : direct_reg[n];
    end
  end

  // change events: inputs, outputs, rejected writes
  wire logic [NIN-1:0] inChg = inPins ^ inSmp_reg;
  wire logic [NOUT-1:0] outChg = out_next ^ out_reg;
  wire logic errEv = wrExprRange && !newOk;
  logic [31:0] events;
  always_comb begin
    events = `RST_WORD;
    events[`ST_IN_LSB +: NIN] = inChg;
    events[`ST_OUT_LSB +: NOUT] = outChg;
    events[`ST_ERR_LSB] = errEv;
  end

  // read mux
  logic [31:0] rdMux;
  always_comb begin
    rdMux = `RST_WORD;
    case (addr)
      `ADDR_CTRL: rdMux[NOUT-1:0] = ctrl_reg;
      `ADDR_SOFT: rdMux[NIN-1:0] = soft_reg;
      `ADDR_DIRECT: rdMux[NOUT-1:0] = direct_reg;
      `ADDR_STATUS: rdMux = status_reg;
      `ADDR_MASK: rdMux = mask_reg;
      `ADDR_ERR: rdMux[0] = status_reg[`ST_ERR_LSB];
      `ADDR_INPUTS: rdMux[NIN-1:0] = inSmp_reg;
      `ADDR_OUTPUTS: rdMux[NOUT-1:0] = out_reg;
      default: begin
        // expression slots read back, others zero
        if (addr >= `ADDR_EXPR0 && addr < 8'(`ADDR_EXPR0 + 4 * NOUT)) begin
          rdMux[$bits(expr_s)-1:0] = expr_reg[exprIdx];
        end
      end
    endcase
  end

  // host written registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= '0;
      soft_reg <= '0;
      direct_reg <= '0;
      mask_reg <= `RST_WORD;
    end else begin
      if (wrCtrl) ctrl_reg <= wdata[NOUT-1:0];
      // RULE16: soft inputs from host image
      if (wrSoft) soft_reg <= wdata[NIN-1:0];
      if (wrDirect) direct_reg <= wdata[NOUT-1:0];
      if (wrMask) mask_reg <= wdata;
    end
  end

  // expression store, one independent slot per output
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // RULE8: all fields none after reset
      for (int n = 0; n < NOUT; n++) expr_reg[n] <= '0;
    end else begin
      // RULE18: only valid shapes replace old one
      if (wrExprRange && newOk) expr_reg[exprIdx] <= newExpr;
    end
  end

  // sampling, output state and read data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inSmp_reg <= '0;
      out_reg <= '0;
      rdata_reg <= `RST_WORD;
    end else begin
      // RULE19: sample inputs every cycle
      inSmp_reg <= inPins;
      out_reg <= out_next;
      rdata_reg <= rd ? rdMux : `RST_WORD;
    end
  end

  // RULE3: sticky change flags, set beats clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) status_reg <= `RST_WORD;
    else status_reg <= (status_reg & ~(wrStatus ? wdata : 32'h0000_0000)) | events;
  end

  assign outPins = out_reg;
  assign rdata = rdata_reg;
  assign irq = |(status_reg & mask_reg);

  // assertions
  // a refused expression write
  sequence s_badWrite;
    wrExprRange && !newOk;
  endsequence
  // an accepted expression write
  sequence s_goodWrite;
    wrExprRange && newOk;
  endsequence
  a_good_applied: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
    s_goodWrite |=> expr_reg[$past(exprIdx)] == $past(newExpr)) else $error("valid shape lost");
  a_full_shape: assert property (@(posedge clk) disable iff (!arst_n) // RULE13
    wrExprRange && used(newExpr.a) && used(newExpr.b) && used(newExpr.c)
    && newExpr.opX != OP_NONE && newExpr.opY != OP_NONE |-> newOk)
    else $error("full shape refused");
  a_two_shape: assert property (@(posedge clk) disable iff (!arst_n) // RULE12
    wrExprRange && newExpr.opY != OP_NONE && newExpr.c.kind == SRC_NONE |-> !newOk)
    else $error("second operator without third operand taken");
  a_one_shape: assert property (@(posedge clk) disable iff (!arst_n) // RULE11
    s_goodWrite && newExpr.opX == OP_NONE && newExpr.a.kind != SRC_NONE
    |-> newExpr.b.kind == SRC_NONE && newExpr.c.kind == SRC_NONE && newExpr.opY == OP_NONE)
    else $error("single operand shape with extra fields");
  a_xor_two: assert property (@(posedge clk) disable iff (!arst_n) // RULE17
    ctrl_reg[3] && expr_reg[3].opX == OP_XOR && expr_reg[3].opY == OP_NONE
    && expr_reg[3].a.kind == SRC_IN && expr_reg[3].b.kind == SRC_SOFT
    |=> out_reg[3] == $past(inSmp_reg[expr_reg[3].a.idx] ^ soft_reg[expr_reg[3].b.idx]))
    else $error("xor result wrong");
  a_full_order: assert property (@(posedge clk) disable iff (!arst_n) // RULE7
    ctrl_reg[2] && expr_reg[2].a.kind == SRC_SOFT_N && expr_reg[2].b.kind == SRC_IN
    && expr_reg[2].c.kind == SRC_IN && expr_reg[2].opX == OP_OR && expr_reg[2].opY == OP_AND
    |=> out_reg[2] == $past((~soft_reg[expr_reg[2].a.idx] | inSmp_reg[expr_reg[2].b.idx])
      & inSmp_reg[expr_reg[2].c.idx])) else $error("full expression order wrong");
  a_soft_take: assert property (@(posedge clk) disable iff (!arst_n) // RULE16
    wrSoft |=> soft_reg == $past(wdata[NIN-1:0])) else $error("soft inputs not taken");
  a_ctrl_take: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
    wrCtrl |=> ctrl_reg == $past(wdata[NOUT-1:0])) else $error("mode select not taken");
  a_direct_three: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
    !ctrl_reg[3] |=> out_reg[3] == $past(direct_reg[3])) else $error("direct drive lost");
  a_err_clear: assert property (@(posedge clk) disable iff (!arst_n) // RULE18
    wrStatus && wdata[`ST_ERR_LSB] && !errEv |=> !status_reg[`ST_ERR_LSB])
    else $error("error flag not cleared");
  a_in_all: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
    |(inPins ^ inSmp_reg) |=> (status_reg[`ST_IN_LSB +: NIN] & $past(inPins ^ inSmp_reg))
      == $past(inPins ^ inSmp_reg)) else $error("input change flag missed");
  a_out_all: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
    $changed(out_reg) |-> (status_reg[`ST_OUT_LSB +: NOUT] & (out_reg ^ $past(out_reg)))
      == (out_reg ^ $past(out_reg))) else $error("output change flag missed");
  a_expr_follow: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
    ctrl_reg[0] |=> out_reg[0] == $past(exprVal[0])) else $error("output not following expression");
  a_direct_follow: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
    !ctrl_reg[1] |=> out_reg[1] == $past(direct_reg[1])) else $error("direct drive lost");
  a_null_off: assert property (@(posedge clk) disable iff (!arst_n) // RULE9
    expr_reg[2] == '0 && ctrl_reg[2] |=> !out_reg[2]) else $error("null expression not off");
  a_bad_kept: assert property (@(posedge clk) disable iff (!arst_n) // RULE18
    s_badWrite |=> expr_reg[$past(exprIdx)] == $past(expr_reg[exprIdx]))
    else $error("invalid expression applied");
  a_bad_flag: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
    s_badWrite |=> status_reg[`ST_ERR_LSB]) else $error("error not flagged");
  a_in_irq: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
    (inPins[0] != inSmp_reg[0]) |=> status_reg[`ST_IN_LSB]) else $error("input change missed");
  a_out_irq: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
    $changed(out_reg[0]) |-> status_reg[`ST_OUT_LSB]) else $error("output change missed");
  a_single_op: assert property (@(posedge clk) disable iff (!arst_n) // RULE11
    expr_reg[0].a.kind == SRC_IN && expr_reg[0].opX == OP_NONE && ctrl_reg[0]
    |=> out_reg[0] == $past(inSmp_reg[expr_reg[0].a.idx])) else $error("single operand wrong");
  a_sample: assert property (@(posedge clk) disable iff (!arst_n) // RULE19
    ##1 inSmp_reg == $past(inPins)) else $error("input sample stale");
  a_irq_level: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
    irq == |(status_reg & mask_reg)) else $error("interrupt level wrong");
endmodule
`default_nettype wire

// file: sim/host_model.sv
// host controller model on the register port
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [31:0] rdata
);
  // bus idles with strobes low
  initial begin
    addr = 8'hFF;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // released data is scrambled so a stale value cannot pass
    wdata <= ~d;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
endmodule
`default_nettype wire

// file: sim/bool_eval_tb.sv
// self-checking bench for the boolean output evaluator
`timescale 1ns/1ps
`include "bool_eval_defs.svh"
`default_nettype none
module bool_eval_tb;
  logic clk;
  logic arstN;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic wr;
  logic rd;
  logic irq;
  logic [7:0] inPins;
  logic [3:0] outPins;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  bool_eval dut_u (.clk(clk), .arst_n(arstN), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .inPins(inPins), .outPins(outPins), .irq(irq));
  host_model host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard, the run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    host_u.rdReg(a, rv);
    check(rv, exp);
  endtask
  // inputs reach outputs two edges later; three leave margin
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [31:0] opd(input int k, input int ix);
    return 32'(k * 8 + ix);
  endfunction
  task automatic resetVals();
    for (int i = 0; i < 4; i++) rdChk(8'(`ADDR_EXPR0 + 4 * i), 32'h0000_0000);
    rdChk(`ADDR_CTRL, 32'h0000_0000);
    rdChk(8'hFC, 32'h0000_0000);
    check({28'h000_0000, outPins}, 32'h0000_0000);
  endtask
  task automatic directDrive();
    host_u.wrReg(`ADDR_DIRECT, 32'h0000_000A);
    settle();
    check({28'h000_0000, outPins}, 32'h0000_000A);
  endtask
  // one expression shape per output, every operand kind and operator
  task automatic exprTable();
    logic [2:0] n;
    logic [3:0] e;
    host_u.wrReg(`ADDR_EXPR0, opd(1, 1));
    host_u.wrReg(8'h24, 32'(opd(1, 1) | opd(3, 2) << 6 | opd(2, 3) << 12 | 2 << 18 | 3 << 20));
    host_u.wrReg(8'h28, 32'(opd(4, 0) | opd(1, 1) << 6 | opd(1, 3) << 12 | 1 << 18 | 2 << 20));
    host_u.wrReg(8'h2C, 32'(opd(1, 1) | opd(3, 2) << 6 | 3 << 18));
    host_u.wrReg(`ADDR_CTRL, 32'h0000_000F);
    for (int i = 0; i < 8; i++) begin
      n = 3'(i);
      host_u.wrReg(`ADDR_SOFT, {29'h0000_0000, n[1], 1'b0, n[1]});
      inPins <= {4'h0, n[2], 1'b0, n[0], 1'b0};
      settle();
      e = {n[0] ^ n[1], (~n[1] | n[0]) & n[2], (n[0] & n[1]) ^ ~n[2], n[0]};
      check({28'h000_0000, outPins}, {28'h000_0000, e});
    end
  endtask
  // malformed words are refused and flagged
  task automatic badShape();
    logic [31:0] bad [4];
    bad = '{32'(opd(1, 1) << 6), 32'(opd(1, 0) | opd(1, 1) << 12), 32'h0000_0028,
      32'(opd(1, 0) | opd(1, 1) << 6)};
    for (int i = 0; i < 4; i++) begin
      host_u.wrReg(`ADDR_STATUS, 32'hFFFF_FFFF);
      host_u.wrReg(`ADDR_EXPR0, bad[i]);
      rdChk(`ADDR_EXPR0, opd(1, 1));
      host_u.rdReg(`ADDR_STATUS, rv);
      check(rv & 32'h0000_1000, 32'h0000_1000);
    end
    host_u.wrReg(`ADDR_STATUS, 32'hFFFF_FFFF);
    host_u.wrReg(`ADDR_EXPR0, 32'h0000_0000);
    inPins <= 8'hFF;
    settle();
    check({31'h0000_0000, outPins[0]}, 32'h0000_0000);
    host_u.rdReg(`ADDR_STATUS, rv);
    check(rv & 32'h0000_1000, 32'h0000_0000);
  endtask
  task automatic irqFlow();
    host_u.wrReg(`ADDR_MASK, 32'h0000_0001);
    host_u.wrReg(`ADDR_STATUS, 32'hFFFF_FFFF);
    @(negedge clk);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    inPins <= 8'hFE;
    settle();
    check({31'h0000_0000, irq}, 32'h0000_0001);
    host_u.wrReg(`ADDR_STATUS, 32'h0000_0001);
    @(negedge clk);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    host_u.wrReg(`ADDR_MASK, 32'h0000_0F00);
    host_u.wrReg(`ADDR_CTRL, 32'h0000_0000);
    host_u.wrReg(`ADDR_DIRECT, 32'h0000_0005);
    settle();
    check({31'h0000_0000, irq}, 32'h0000_0001);
  endtask
  initial begin
    arstN = 1'b0;
    inPins = 8'h00;
    repeat (2) @(posedge clk);
    arstN <= 1'b1;
    resetVals();
    directDrive();
    exprTable();
    badShape();
    irqFlow();
    report_and_stop();
  end
endmodule
`default_nettype wire
